//--- pkg/fifo_rd_pkg.sv
// Purpose: Shared constants and types for the single-clock FIFO with read-side handshaking.
// Assumes: One clock, APB register access, flip-flop storage.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package fifo_rd_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_NEAR_FULL = 5'h0f;
  localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_WDATA = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_RDATA = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RDREQ = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_MODE_BIT = 0;
  localparam int ST_FLAGS_LSB = 0;
  localparam int ST_HS_LSB = 4;
  localparam int ST_WORDS_LSB = 8;
  localparam int ST_COUNT_LSB = 16;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic full;
    logic almost_full;
    logic empty;
    logic almost_empty;
  } flags_t;

  typedef struct packed {
    logic valid;
    logic underflow;
    logic wr_ack;
    logic overflow;
  } hs_t;

  localparam flags_t FLAGS_RESET = 4'h3;
  localparam hs_t HS_IDLE = 4'h0;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_RESP = 2'b10
  } apb_state_t;

endpackage

//--- hw/fifo_read_side_handshake.sv
// Purpose: Single-clock FIFO with standard and fall-through read modes and handshake flags.
// Assumes: User write and read logic run on pclk; software uses APB.
// Notes: Mode changes are accepted only while the buffer holds no words.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

module fifo_read_side_handshake #(
  parameter logic [3:0] HS_ENABLE = 4'hf,
  parameter logic [3:0] HS_ACTIVE_LOW = 4'h0,
  parameter bit SHIFT_REG_IMPL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fifo_rd_pkg::ADDR_W-1:0] paddr,
  input wire logic [fifo_rd_pkg::DATA_W-1:0] pwdata,
  output var logic pready,
  output var logic [fifo_rd_pkg::DATA_W-1:0] prdata,
  output var logic pslverr,
  input wire logic wr_en,
  input wire logic [fifo_rd_pkg::DATA_W-1:0] din,
  input wire logic rd_en,
  output var logic [fifo_rd_pkg::DATA_W-1:0] dout,
  output var fifo_rd_pkg::flags_t flags,
  output var fifo_rd_pkg::hs_t hs
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fifo_rd_pkg::apb_state_t apb_q, apb_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [fifo_rd_pkg::DATA_W-1:0] prdata_q, prdata_d;
  logic fall_through_mode_q, fall_through_mode_d;
  logic apb_fire, apb_wr, apb_rd, mode_wr;
  logic wr_in, rd_in, push, pop, full_now;
  logic rd_ok, out_adv, s1_adv;
  logic [fifo_rd_pkg::DATA_W-1:0] mem_q [fifo_rd_pkg::DEPTH];
  logic [fifo_rd_pkg::DATA_W-1:0] wdata;
  logic [fifo_rd_pkg::PTR_W-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [fifo_rd_pkg::CNT_W-1:0] count_q, count_d, words_q, words_d;
  logic [fifo_rd_pkg::DATA_W-1:0] s1_q, s1_d, dout_q, dout_d;
  logic s1_v_q, s1_v_d, out_v_q, out_v_d;
  fifo_rd_pkg::flags_t flags_q, flags_d;
  fifo_rd_pkg::hs_t hs_raw_q, hs_raw_d, hs_q, hs_d;
  logic started_q;

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign dout = dout_q;
  assign flags = flags_q;
  assign hs = hs_q;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // The answer is registered, so every access phase lasts two cycles.
  assign apb_fire = (apb_q == fifo_rd_pkg::APB_RESP) && psel && penable;
  assign apb_wr = apb_fire && pwrite && (paddr == fifo_rd_pkg::ADDR_WDATA);
  assign apb_rd = apb_fire && pwrite && (paddr == fifo_rd_pkg::ADDR_RDREQ);
  assign mode_wr = apb_fire && pwrite && (paddr == fifo_rd_pkg::ADDR_CTRL);

  always_comb begin
    apb_d = apb_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    fall_through_mode_d = fall_through_mode_q;
    case (apb_q)
      fifo_rd_pkg::APB_IDLE: begin
        if (psel && penable) begin
          apb_d = fifo_rd_pkg::APB_RESP;
          pready_d = 1'b1;
          prdata_d = fifo_rd_pkg::WORD_ZERO;
          if (paddr == fifo_rd_pkg::ADDR_CTRL) begin
            prdata_d[fifo_rd_pkg::CTRL_MODE_BIT] = fall_through_mode_q;
          end else if (paddr == fifo_rd_pkg::ADDR_RDATA) begin
            prdata_d = dout_q;
          end else if (paddr == fifo_rd_pkg::ADDR_STATUS) begin
            prdata_d[fifo_rd_pkg::ST_FLAGS_LSB +: 4] = flags_q;
            prdata_d[fifo_rd_pkg::ST_HS_LSB +: 4] = hs_raw_q;
            prdata_d[fifo_rd_pkg::ST_WORDS_LSB +: fifo_rd_pkg::CNT_W] = words_q;
            prdata_d[fifo_rd_pkg::ST_COUNT_LSB +: fifo_rd_pkg::CNT_W] = count_q;
          end else if (paddr != fifo_rd_pkg::ADDR_WDATA && paddr != fifo_rd_pkg::ADDR_RDREQ) begin
            pslverr_d = 1'b1;
          end
        end
      end
      fifo_rd_pkg::APB_RESP: begin
        apb_d = fifo_rd_pkg::APB_IDLE;
      end
      default: begin
        apb_d = fifo_rd_pkg::APB_IDLE;
      end
    endcase
    // Switching mode with words in flight would strand them in the output stages.
    if (mode_wr && words_q == fifo_rd_pkg::CNT_ZERO && !SHIFT_REG_IMPL) begin
      fall_through_mode_d = pwdata[fifo_rd_pkg::CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_q <= fifo_rd_pkg::APB_IDLE;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= fifo_rd_pkg::WORD_ZERO;
      fall_through_mode_q <= 1'b0;
    end else begin
      apb_q <= apb_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      fall_through_mode_q <= fall_through_mode_d;
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  assign wr_in = wr_en || apb_wr;
  assign rd_in = rd_en || apb_rd;
  assign wdata = wr_en ? din : pwdata;
  assign full_now = (count_q == fifo_rd_pkg::CNT_FULL);
  assign push = wr_in && !full_now;

  genvar gi;
  generate
    for (gi = 0; gi < fifo_rd_pkg::DEPTH; gi++) begin : g_entry
      logic [fifo_rd_pkg::DATA_W-1:0] ent_d;
      always_comb begin
        ent_d = mem_q[gi];
        if (push && wptr_q == (fifo_rd_pkg::PTR_W)'(gi)) begin
          ent_d = wdata;
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_q[gi] <= fifo_rd_pkg::WORD_ZERO;
        end else begin
          mem_q[gi] <= ent_d;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read path and flags
  // ----------------------------------------------------------------
  // Fall-through uses two output stages, which is where the extra depth lives.
  assign rd_ok = rd_in && out_v_q;
  assign out_adv = !out_v_q || rd_ok;
  assign s1_adv = !s1_v_q || out_adv;

  always_comb begin
    pop = 1'b0;
    s1_d = s1_q;
    s1_v_d = 1'b0;
    out_v_d = 1'b0;
    dout_d = dout_q;
    hs_raw_d = fifo_rd_pkg::HS_IDLE;
    if (fall_through_mode_q) begin
      pop = s1_adv && (count_q != fifo_rd_pkg::CNT_ZERO);
      s1_v_d = s1_adv ? (count_q != fifo_rd_pkg::CNT_ZERO) : s1_v_q;
      if (pop) begin
        s1_d = mem_q[rptr_q];
      end
      out_v_d = out_adv ? s1_v_q : out_v_q;
      if (out_adv && s1_v_q) begin
        dout_d = s1_q;
      end
      hs_raw_d.valid = out_v_d;
      hs_raw_d.underflow = rd_in && !out_v_q;
    end else begin
      pop = rd_in && (count_q != fifo_rd_pkg::CNT_ZERO);
      if (pop) begin
        dout_d = mem_q[rptr_q];
      end
      hs_raw_d.valid = pop;
      hs_raw_d.underflow = rd_in && (count_q == fifo_rd_pkg::CNT_ZERO);
    end
    hs_raw_d.wr_ack = push;
    hs_raw_d.overflow = wr_in && full_now;
    wptr_d = push ? wptr_q + fifo_rd_pkg::PTR_ONE : wptr_q;
    rptr_d = pop ? rptr_q + fifo_rd_pkg::PTR_ONE : rptr_q;
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + fifo_rd_pkg::CNT_ONE;
    end else if (pop && !push) begin
      count_d = count_q - fifo_rd_pkg::CNT_ONE;
    end
    words_d = count_d + {{(fifo_rd_pkg::CNT_W-1){1'b0}}, s1_v_d}
      + {{(fifo_rd_pkg::CNT_W-1){1'b0}}, out_v_d};
    flags_d.full = (count_d == fifo_rd_pkg::CNT_FULL);
    flags_d.almost_full = (count_d == fifo_rd_pkg::CNT_NEAR_FULL);
    flags_d.empty = fall_through_mode_q ? !out_v_d : (count_d == fifo_rd_pkg::CNT_ZERO);
    flags_d.almost_empty = (words_d == fifo_rd_pkg::CNT_ONE);
    hs_d = (hs_raw_d & HS_ENABLE) ^ HS_ACTIVE_LOW;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr_q <= '0;
      rptr_q <= '0;
      count_q <= fifo_rd_pkg::CNT_ZERO;
      words_q <= fifo_rd_pkg::CNT_ZERO;
      s1_q <= fifo_rd_pkg::WORD_ZERO;
      s1_v_q <= 1'b0;
      out_v_q <= 1'b0;
      dout_q <= fifo_rd_pkg::WORD_ZERO;
      flags_q <= fifo_rd_pkg::FLAGS_RESET;
      hs_raw_q <= fifo_rd_pkg::HS_IDLE;
      hs_q <= HS_ACTIVE_LOW;
      started_q <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      count_q <= count_d;
      words_q <= words_d;
      s1_q <= s1_d;
      s1_v_q <= s1_v_d;
      out_v_q <= out_v_d;
      dout_q <= dout_d;
      flags_q <= flags_d;
      hs_raw_q <= hs_raw_d;
      hs_q <= hs_d;
      started_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_first_write_ft;
    fall_through_mode_q && words_q == fifo_rd_pkg::CNT_ZERO && wr_in && !mode_wr;
  endsequence

  sequence s_fall_through_wait;
    flags_q.empty ##1 flags_q.empty ##1 !flags_q.empty && hs_raw_q.valid;
  endsequence

  a_std_read_valid: assert property (
    !fall_through_mode_q && rd_in && !flags_q.empty
      |=> hs_raw_q.valid && dout_q == $past(mem_q[rptr_q])
  ) else $error("standard read did not present data with valid");

  a_underflow_empty: assert property (
    rd_in && flags_q.empty && count_q == fifo_rd_pkg::CNT_ZERO
      |=> hs_raw_q.underflow && rptr_q == $past(rptr_q)
  ) else $error("read while empty did not underflow cleanly");

  a_near_empty_one: assert property (
    started_q |-> flags_q.almost_empty == ((count_q + {{(fifo_rd_pkg::CNT_W-1){1'b0}}, s1_v_q}
      + {{(fifo_rd_pkg::CNT_W-1){1'b0}}, out_v_q}) == fifo_rd_pkg::CNT_ONE)
  ) else $error("near-empty disagrees with word count");

  a_empty_simul: assert property (
    !fall_through_mode_q && flags_q.empty && wr_in && rd_in
      |=> !flags_q.empty && hs_raw_q.underflow
  ) else $error("simultaneous access while empty misbehaved");

  a_ft_empty_latency: assert property (
    s_first_write_ft |=> s_fall_through_wait
  ) else $error("fall-through empty did not clear on the third edge");

  a_std_last_word: assert property (
    !fall_through_mode_q && rd_in && !wr_in && count_q == fifo_rd_pkg::CNT_ONE
      |=> flags_q.empty && hs_raw_q.valid ##1 !hs_raw_q.valid
  ) else $error("standard last read timing wrong");

  a_ft_last_word: assert property (
    fall_through_mode_q && rd_in && !wr_in && words_q == fifo_rd_pkg::CNT_ONE && out_v_q
      |=> flags_q.empty && !hs_raw_q.valid
  ) else $error("fall-through last read did not drop valid with empty");

  a_write_ack: assert property (
    wr_in && !flags_q.full |=> hs_raw_q.wr_ack && !hs_raw_q.overflow
  ) else $error("successful write not acknowledged");

  a_overflow_keep: assert property (
    wr_in && flags_q.full |=> hs_raw_q.overflow && !hs_raw_q.wr_ack && $stable(wptr_q)
  ) else $error("write while full was not refused");

  a_flags_steady: assert property (
    !fall_through_mode_q && wr_in && rd_in && !flags_q.empty && !flags_q.full
      && count_q != fifo_rd_pkg::CNT_ONE |=> $stable(flags_q)
  ) else $error("simultaneous access changed the flags");

  a_ft_valid_level: assert property (
    fall_through_mode_q |-> hs_raw_q.valid == out_v_q && flags_q.empty == !out_v_q
  ) else $error("fall-through valid does not follow the output word");

  a_polarity_out: assert property (
    hs_q == ((hs_raw_q & HS_ENABLE) ^ HS_ACTIVE_LOW)
  ) else $error("handshake polarity mapping broken");

endmodule

`default_nettype wire

//--- bench/fifo_user_model.sv
// Purpose: User write and read logic beside the FIFO, one request per clock.
// Assumes: The bench calls step once per cycle; everything runs on pclk.
// Notes: An idle data bus inverts its previous value each cycle, so it alternates between the last word and its inverse.
`timescale 1ns/1ns
`default_nettype none

module fifo_user_model (
  input wire logic pclk,
  output logic wr_en,
  output logic [fifo_rd_pkg::DATA_W-1:0] din,
  output logic rd_en
);
  // ----------------------------------------------------------------
  // Requests
  // ----------------------------------------------------------------
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    din = 32'h5a5a_5a5a;
  end

  // Signals change just after a rising edge, so the FIFO samples them a cycle later.
  task automatic step(input logic w, input logic [fifo_rd_pkg::DATA_W-1:0] d, input logic r);
    @(posedge pclk);
    wr_en <= w;
    rd_en <= r;
    din <= w ? d : ~din;
  endtask
endmodule

`default_nettype wire

//--- bench/test_fifo_read_side_handshake.sv
// Purpose: Self-checking bench for the FIFO read side, handshakes and APB access.
// Assumes: Default build: all handshakes enabled, active high, flip-flop storage.
// Notes: Status is compared as one byte {flags, hs} so flags and handshakes take a single check.
`timescale 1ns/1ns
`default_nettype none

module test_fifo_read_side_handshake;
  localparam logic [31:0] nil = fifo_rd_pkg::WORD_ZERO;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [fifo_rd_pkg::ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, wr_en, rd_en;
  logic [31:0] prdata, din, dout, rd;
  fifo_rd_pkg::flags_t flags;
  fifo_rd_pkg::hs_t hs;
  int err_count = 0;
  int n_checks = 0;

  always #5 pclk = ~pclk;

  fifo_read_side_handshake i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .wr_en(wr_en), .din(din), .rd_en(rd_en),
    .dout(dout), .flags(flags), .hs(hs));
  fifo_user_model i_user (.pclk(pclk), .wr_en(wr_en), .din(din), .rd_en(rd_en));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] wd(input int i);
    return 32'ha5a5_0000 + 32'(i);
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic st(input logic [7:0] e);
    chk("flags_hs", 32'({flags, hs}), 32'(e));
  endtask

  // Returns settled state after the edge that sampled the previous request.
  task automatic cyc(input logic w, input logic [31:0] d, input logic r);
    i_user.step(w, d, r);
    #1;
  endtask

  // The master waits for pready with no assumed latency; a bound of 20 cycles ends a hang.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_count++;
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    logic e;
    repeat (20) @(posedge pclk);
    st(8'h30);
    chk("dout", dout, nil);
    presetn <= 1'b1;
    cyc(1'b0, nil, 1'b0);
    st(8'h20);
    cyc(1'b1, 32'h1111_1111, 1'b0);
    cyc(1'b0, nil, 1'b1);
    st(8'h12);
    cyc(1'b0, nil, 1'b0);
    st(8'h28);
    chk("dout", dout, 32'h1111_1111);
    cyc(1'b0, nil, 1'b1);
    cyc(1'b1, 32'h2222_2222, 1'b1);
    st(8'h24);
    cyc(1'b1, wd(0), 1'b1);
    st(8'h16);
    chk("dout", dout, 32'h1111_1111);
    cyc(1'b0, nil, 1'b0);
    st(8'h1a);
    chk("dout", dout, 32'h2222_2222);
    for (int i = 1; i < 16; i++) begin
      cyc(1'b1, wd(i), 1'b0);
      if (i == 15) st(8'h42);
    end
    cyc(1'b1, wd(77), 1'b0);
    st(8'h82);
    cyc(1'b0, nil, 1'b0);
    st(8'h81);
    for (int i = 0; i < 16; i++) begin
      cyc(1'b0, nil, 1'b1);
      if (i > 0) chk("dout", dout, wd(i - 1));
    end
    cyc(1'b0, nil, 1'b0);
    chk("dout", dout, wd(15));
    st(8'h28);
    apb(1'b0, fifo_rd_pkg::ADDR_STATUS, nil, e);
    chk("status", rd, 32'h0000_0002);
    apb(1'b0, 8'h40, nil, e);
    chk("pslverr", 32'(e), 32'h0000_0001);
    apb(1'b1, fifo_rd_pkg::ADDR_CTRL, 32'h0000_0001, e);
    apb(1'b1, fifo_rd_pkg::ADDR_WDATA, wd(20), e);
    repeat (3) cyc(1'b0, nil, 1'b0);
    apb(1'b0, fifo_rd_pkg::ADDR_RDATA, nil, e);
    chk("rdata", rd, wd(20));
    cyc(1'b0, nil, 1'b1);
    st(8'h18);
    cyc(1'b0, nil, 1'b1);
    st(8'h20);
    cyc(1'b0, nil, 1'b0);
    st(8'h24);
    cyc(1'b1, wd(21), 1'b0);
    cyc(1'b0, nil, 1'b0);
    chk("empty", 32'(flags.empty), 32'h0000_0001);
    cyc(1'b0, nil, 1'b0);
    chk("empty", 32'(flags.empty), 32'h0000_0001);
    cyc(1'b0, nil, 1'b1);
    st(8'h18);
    chk("dout", dout, wd(21));
    cyc(1'b0, nil, 1'b0);
    st(8'h20);
    for (int i = 0; i < 18; i++) cyc(1'b1, wd(32 + i), 1'b0);
    repeat (4) cyc(1'b0, nil, 1'b0);
    st(8'h88);
    apb(1'b0, fifo_rd_pkg::ADDR_STATUS, nil, e);
    chk("status", rd, 32'h0010_1288);
    cyc(1'b1, wd(99), 1'b0);
    cyc(1'b0, nil, 1'b0);
    st(8'h89);
    for (int i = 0; i < 18; i++) begin
      cyc(1'b0, nil, 1'b1);
      chk("dout", dout, wd(32 + i));
    end
    cyc(1'b0, nil, 1'b0);
    st(8'h20);
    finish_test();
  end

  // Whole run is about 140 cycles; this span only cuts a hang short.
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    finish_test();
  end
endmodule

`default_nettype wire
